//--- logic/adc_regmap_pkg.sv
/*
 * register map constants, field layout and carrier types for the
 * dual-channel converter configuration bank.
 * assumes a serial front end that turns frames into byte-wide requests.
 */
package adc_regmap_pkg;

    // register offsets
    localparam logic [7:0] ADDR_PORT_CFG = 8'h00;
    localparam logic [7:0] ADDR_PART_ID = 8'h01;
    localparam logic [7:0] ADDR_SPEED_GRADE = 8'h02;
    localparam logic [7:0] ADDR_CH_SEL = 8'h05;
    localparam logic [7:0] ADDR_POWER_MODE = 8'h08;
    localparam logic [7:0] ADDR_CLOCK_COND = 8'h09;
    localparam logic [7:0] ADDR_CLOCK_DIV = 8'h0B;
    localparam logic [7:0] ADDR_COMMIT = 8'hFF;

    // reset values
    localparam logic [7:0] RST_PORT_CFG = 8'h18;
    localparam logic [7:0] RST_CH_SEL = 8'h03;
    localparam logic [7:0] RST_POWER_MODE = 8'h00;
    localparam logic [7:0] RST_CLOCK_COND = 8'h01;
    localparam logic [7:0] RST_CLOCK_DIV = 8'h00;
    localparam logic [7:0] RST_COMMIT = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // port configuration fields, mirrored nibbles
    localparam int PC_LSB_FIRST_HI = 6;
    localparam int PC_LSB_FIRST_LO = 1;
    localparam int PC_SOFT_RST_HI = 5;
    localparam int PC_SOFT_RST_LO = 2;
    localparam logic [7:0] PC_FIXED_ONES = 8'h18;

    // implemented bits of the function registers
    localparam logic [7:0] POWER_MODE_MASK = 8'h23;
    localparam int POWER_PIN_FN_BIT = 5;
    localparam logic [7:0] CLOCK_COND_MASK = 8'h01;
    localparam int DCS_ENABLE_BIT = 0;
    localparam logic [7:0] CLOCK_DIV_MASK = 8'h07;
    localparam int CLOCK_DIV_WIDTH = 3;
    localparam int COMMIT_BIT = 0;
    localparam int SPEED_GRADE_LSB = 4;

    // channel select register width limit
    localparam int CH_SEL_MAX = 8;

    // internal power-down mode field
    typedef enum logic [1:0] {
        PM_NORMAL,
        PM_POWERDOWN,
        PM_STANDBY,
        PM_DIGITAL_RESET
    } power_mode_t;

    // one register request from the serial front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_req_t;

endpackage : adc_regmap_pkg

//--- logic/buffered_reg.sv
/*
 * master/active register pair: software writes the master copy, a commit
 * pulse moves it into the active copy that steers the converter.
 * assumes a synchronous reload input that covers power-on and soft reset.
 */
`timescale 1ns/10ps
module buffered_reg #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic ref_clk_i,
    input wire logic reload_i,
    input wire logic write_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic commit_i,
    output logic [WIDTH-1:0] master_o,
    output logic [WIDTH-1:0] active_o
);

    // master copy, what reads return
    always_ff @(posedge ref_clk_i) begin
        if (reload_i) begin
            master_o <= RESET_VALUE;
        end else if (write_i) begin
            master_o <= wdata_i;
        end
    end

    // active copy, only moves on commit or reload
    always_ff @(posedge ref_clk_i) begin
        if (reload_i) begin
            active_o <= RESET_VALUE;
        end else if (commit_i) begin
            active_o <= master_o;
        end
    end

endmodule : buffered_reg

//--- logic/dual_adc_register_map.sv
/*
 * configuration register bank of a dual-channel converter: port setup,
 * identification, channel select, commit and the power, stabilizer and
 * clock divider function registers, with per-channel local copies.
 * assumes a serial front end that delivers one byte request per cycle
 * on req_i and honours lsb_first_o when shifting.
 */
// Summary of operation
// - any reset reloads documented defaults
// - local registers duplicated per channel, select-steered
// - both selects set writes both copies
// - both selects set reads channel A copy
// - channel select resets to 0x03
// - global registers hold one shared copy
// - port config mirrored, fixed ones, reset 0x18
// - commit bit moves master into active
// - power mode field and pin function
// - stabilizer enable bit, resets enabled
// - divider ratio is field plus one
`timescale 1ns/10ps
module dual_adc_register_map import adc_regmap_pkg::*; #(
    parameter int NUM_CHANNELS = 2,
    parameter logic [7:0] PART_ID = 8'h5A, // arbitrary value
    parameter logic [2:0] SPEED_GRADE = 3'h1 // arbitrary value
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire reg_req_t req_i,
    input wire logic external_powerdown_pin_i,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    output logic lsb_first_o,
    output logic stabilizer_en_o,
    output logic [CLOCK_DIV_WIDTH:0] clk_div_ratio_o,
    output logic [NUM_CHANNELS-1:0] powerdown_o,
    output logic [NUM_CHANNELS-1:0] standby_o,
    output logic [NUM_CHANNELS-1:0] digital_reset_o
);

    // refuse channel counts the select register cannot address
    if (NUM_CHANNELS < 1 || NUM_CHANNELS > CH_SEL_MAX) begin : g_bad_channels
        $error("channel count outside select register range");
    end

    // lowest selected channel wins a local read
    function automatic int first_channel(input logic [NUM_CHANNELS-1:0] sel);
        int idx;
        idx = 0;
        for (int i = NUM_CHANNELS - 1; i >= 0; i--) begin
            if (sel[i]) begin
                idx = i;
            end
        end
        return idx;
    endfunction : first_channel

    // write strobe for one address
    function automatic logic write_to(input reg_req_t req, input logic [7:0] addr);
        return req.wr && (req.addr == addr);
    endfunction : write_to

    logic soft_reset_pulse; // one-cycle soft reset pulse
    logic reload; // power-on or soft reset
    logic [NUM_CHANNELS-1:0] ch_sel; // channel select bits
    logic commit_pending; // pending commit, self-clearing
    logic [7:0] pm_master [NUM_CHANNELS]; // per-channel power master
    logic [7:0] pm_active [NUM_CHANNELS]; // per-channel power active
    logic [7:0] clk_master; // shared clock conditioning
    logic [7:0] clk_active;
    logic [7:0] div_master; // shared divider
    logic [7:0] div_active;
    logic [7:0] next_rd_data; // read mux result

    // both reset sources reload defaults
    assign reload = !rstn_i || soft_reset_pulse;

    // soft reset, either mirrored bit, self-clears
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            soft_reset_pulse <= 1'b0;
        end else begin
            soft_reset_pulse <= write_to(req_i, ADDR_PORT_CFG) &&
                (req_i.data[PC_SOFT_RST_HI] || req_i.data[PC_SOFT_RST_LO]);
        end
    end

    // bit order, either mirrored bit counts
    always_ff @(posedge ref_clk_i) begin
        if (reload) begin
            lsb_first_o <= RST_PORT_CFG[PC_LSB_FIRST_LO];
        end else if (write_to(req_i, ADDR_PORT_CFG)) begin
            lsb_first_o <= req_i.data[PC_LSB_FIRST_HI] || req_i.data[PC_LSB_FIRST_LO];
        end
    end

    // channel select, reset to both channels
    always_ff @(posedge ref_clk_i) begin
        if (reload) begin
            ch_sel <= RST_CH_SEL[NUM_CHANNELS-1:0];
        end else if (write_to(req_i, ADDR_CH_SEL)) begin
            ch_sel <= req_i.data[NUM_CHANNELS-1:0];
        end
    end

    // commit flag: a new set wins over the self-clear
    always_ff @(posedge ref_clk_i) begin
        if (reload) begin
            commit_pending <= RST_COMMIT[COMMIT_BIT];
        end else if (write_to(req_i, ADDR_COMMIT) && req_i.data[COMMIT_BIT]) begin
            commit_pending <= 1'b1;
        end else if (commit_pending) begin
            commit_pending <= 1'b0;
        end
    end

    // per-channel local power mode copies
    for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_channel
        logic [$bits(power_mode_t)-1:0] mode_field; // active internal mode
        logic pin_to_standby; // active pin function

        assign mode_field = pm_active[ch][$bits(power_mode_t)-1:0];
        assign pin_to_standby = pm_active[ch][POWER_PIN_FN_BIT];

        // write only when this channel is selected
        buffered_reg #(
            .WIDTH(8),
            .RESET_VALUE(RST_POWER_MODE)
        ) u_power_mode (
            .ref_clk_i(ref_clk_i),
            .reload_i(reload),
            .write_i(write_to(req_i, ADDR_POWER_MODE) && ch_sel[ch]),
            .wdata_i(req_i.data & POWER_MODE_MASK),
            .commit_i(commit_pending),
            .master_o(pm_master[ch]),
            .active_o(pm_active[ch])
        );

        // decode mode field and pin function into controls
        always_ff @(posedge ref_clk_i) begin
            if (!rstn_i) begin
                powerdown_o[ch] <= 1'b0;
                standby_o[ch] <= 1'b0;
                digital_reset_o[ch] <= 1'b0;
            end else begin
                powerdown_o[ch] <= 1'b0;
                standby_o[ch] <= 1'b0;
                digital_reset_o[ch] <= 1'b0;
                unique case (power_mode_t'(mode_field))
                    PM_NORMAL: begin
                        powerdown_o[ch] <= external_powerdown_pin_i && !pin_to_standby;
                        standby_o[ch] <= external_powerdown_pin_i && pin_to_standby;
                    end
                    PM_POWERDOWN: begin
                        powerdown_o[ch] <= 1'b1;
                    end
                    PM_STANDBY: begin
                        standby_o[ch] <= 1'b1;
                    end
                    PM_DIGITAL_RESET: begin
                        digital_reset_o[ch] <= 1'b1;
                    end
                endcase
            end
        end
    end

    // shared clock conditioning register
    buffered_reg #(
        .WIDTH(8),
        .RESET_VALUE(RST_CLOCK_COND)
    ) u_clock_cond (
        .ref_clk_i(ref_clk_i),
        .reload_i(reload),
        .write_i(write_to(req_i, ADDR_CLOCK_COND)),
        .wdata_i(req_i.data & CLOCK_COND_MASK),
        .commit_i(commit_pending),
        .master_o(clk_master),
        .active_o(clk_active)
    );

    // shared clock divider register
    buffered_reg #(
        .WIDTH(8),
        .RESET_VALUE(RST_CLOCK_DIV)
    ) u_clock_div (
        .ref_clk_i(ref_clk_i),
        .reload_i(reload),
        .write_i(write_to(req_i, ADDR_CLOCK_DIV)),
        .wdata_i(req_i.data & CLOCK_DIV_MASK),
        .commit_i(commit_pending),
        .master_o(div_master),
        .active_o(div_active)
    );

    // stabilizer enable and divide ratio from active copies
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            stabilizer_en_o <= RST_CLOCK_COND[DCS_ENABLE_BIT];
            clk_div_ratio_o <= (CLOCK_DIV_WIDTH + 1)'(RST_CLOCK_DIV[CLOCK_DIV_WIDTH-1:0]) + 1'b1;
        end else begin
            stabilizer_en_o <= clk_active[DCS_ENABLE_BIT];
            clk_div_ratio_o <= {1'b0, div_active[CLOCK_DIV_WIDTH-1:0]} + 1'b1;
        end
    end

    // read mux, open addresses read as zero
    always_comb begin
        next_rd_data = READ_UNMAPPED;
        case (req_i.addr)
            ADDR_PORT_CFG: begin
                next_rd_data = PC_FIXED_ONES;
                next_rd_data[PC_LSB_FIRST_HI] = lsb_first_o;
                next_rd_data[PC_LSB_FIRST_LO] = lsb_first_o;
            end
            ADDR_PART_ID: begin
                next_rd_data = PART_ID;
            end
            ADDR_SPEED_GRADE: begin
                next_rd_data[SPEED_GRADE_LSB +: $bits(SPEED_GRADE)] = SPEED_GRADE;
            end
            ADDR_CH_SEL: begin
                next_rd_data[NUM_CHANNELS-1:0] = ch_sel;
            end
            ADDR_POWER_MODE: begin
                next_rd_data = pm_master[first_channel(ch_sel)];
            end
            ADDR_CLOCK_COND: begin
                next_rd_data = clk_master;
            end
            ADDR_CLOCK_DIV: begin
                next_rd_data = div_master;
            end
            ADDR_COMMIT: begin
                next_rd_data[COMMIT_BIT] = commit_pending;
            end
            default: begin
                next_rd_data = READ_UNMAPPED;
            end
        endcase
    end

    // registered read answer, one cycle after the request
    always_ff @(posedge ref_clk_i) begin
        if (reload) begin
            rd_data_o <= READ_UNMAPPED;
            rd_valid_o <= 1'b0;
        end else begin
            rd_data_o <= req_i.rd ? next_rd_data : rd_data_o;
            rd_valid_o <= req_i.rd;
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    // reset release leaves both channels selected
    a_chsel_reset: assert property (
        $rose(rstn_i) |-> ch_sel == RST_CH_SEL[NUM_CHANNELS-1:0])
        else $error("channel select not at reset value");
    // soft reset pulse reloads the defaults on the following edge
    a_soft_reload: assert property (
        soft_reset_pulse |=> ch_sel == RST_CH_SEL[NUM_CHANNELS-1:0] && !lsb_first_o
        && div_master == RST_CLOCK_DIV && clk_master == RST_CLOCK_COND)
        else $error("soft reset did not reload defaults");
    // low copy of the bit order bit is honoured on its own
    a_port_mirror: assert property (
        write_to(req_i, ADDR_PORT_CFG) && !soft_reset_pulse
        && req_i.data[PC_LSB_FIRST_LO] |=> lsb_first_o)
        else $error("low mirrored bit order bit ignored");
    // a write with both selects lands in every copy
    a_dual_write: assert property (
        write_to(req_i, ADDR_POWER_MODE) && &ch_sel && !soft_reset_pulse
        |=> pm_master[0] == pm_master[NUM_CHANNELS-1]
        && pm_master[0] == ($past(req_i.data) & POWER_MODE_MASK))
        else $error("dual select write missed a channel");
    // a read with both selects returns the first channel
    a_local_first: assert property (
        req_i.rd && req_i.addr == ADDR_POWER_MODE && &ch_sel && !soft_reset_pulse
        |=> rd_valid_o && rd_data_o == $past(pm_master[0]))
        else $error("dual select read did not return channel A");
    // a pending commit lasts one cycle unless set again
    a_commit_clear: assert property (
        commit_pending && !write_to(req_i, ADDR_COMMIT) && !soft_reset_pulse
        |=> !commit_pending)
        else $error("commit bit did not clear");
    // commit copies the divider, the ratio follows one edge later
    a_commit_copy: assert property (
        commit_pending && !soft_reset_pulse
        |=> div_active == $past(div_master) ##1 clk_div_ratio_o
        == {1'b0, $past(div_active[CLOCK_DIV_WIDTH-1:0])} + 1'b1)
        else $error("commit did not reach the divider ratio");
    // identification reads never change
    a_id_fixed: assert property (
        req_i.rd && req_i.addr == ADDR_PART_ID && !soft_reset_pulse
        |=> rd_data_o == PART_ID)
        else $error("identification read wrong");
    // full power-down mode overrides the pin function
    a_pmode_full: assert property (
        pm_active[0][1:0] == PM_POWERDOWN |=> powerdown_o[0] && !standby_o[0])
        else $error("full power-down mode not decoded");
    // stabilizer enable shows the committed master two edges later
    a_dcs_follow: assert property (
        commit_pending && !soft_reset_pulse
        |=> ##1 stabilizer_en_o == $past(clk_master[DCS_ENABLE_BIT], 2))
        else $error("stabilizer enable does not follow register");

    // main scenarios: dual write, commit, soft reset, bit order change
    c_dual_write: cover property (write_to(req_i, ADDR_POWER_MODE) && &ch_sel);
    c_commit: cover property (commit_pending ##1 !commit_pending);
    c_soft_reset: cover property (soft_reset_pulse);
    c_lsb_first: cover property ($rose(lsb_first_o));

endmodule : dual_adc_register_map

//--- verif/ctrl_master_model.sv
/*
 * behavioural serial control master: turns bench calls into byte requests
 * on the register port of the converter configuration bank.
 * assumes requests are taken at the rising edge, read data one cycle later.
 */
`timescale 1ns/10ps
module ctrl_master_model import adc_regmap_pkg::*; (
    input wire logic ref_clk_i,
    input wire logic [7:0] rd_data_i,
    input wire logic rd_valid_i,
    output reg_req_t req_o
);
    // bits that really exist at each address
    function automatic logic [7:0] impl_mask(input logic [7:0] addr);
        case (addr)
            ADDR_PORT_CFG: return 8'h66;
            ADDR_PART_ID: return 8'hFF;
            ADDR_SPEED_GRADE: return 8'h70;
            ADDR_CH_SEL: return 8'h03;
            ADDR_POWER_MODE: return POWER_MODE_MASK;
            ADDR_CLOCK_COND: return CLOCK_COND_MASK;
            ADDR_CLOCK_DIV: return CLOCK_DIV_MASK;
            ADDR_COMMIT: return 8'h01;
            default: return 8'h00;
        endcase
    endfunction : impl_mask

    // released bus drops both strobes and inverts address and data; with both strobes low neither byte reaches a register
    task automatic idle_bus();
        req_o.wr = 1'b0;
        req_o.rd = 1'b0;
        req_o.addr = ~req_o.addr;
        req_o.data = ~req_o.data;
    endtask : idle_bus

    initial req_o = 18'h00000;

    // one write byte held for one sampling edge
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        if (impl_mask(addr) != 8'h00) begin
            @(negedge ref_clk_i);
            req_o.wr = 1'b1;
            req_o.addr = addr;
            req_o.data = data & impl_mask(addr);
            @(negedge ref_clk_i);
            idle_bus();
        end
    endtask : write_reg

    // one read byte; answer taken in the following cycle
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
                            output logic valid);
        @(negedge ref_clk_i);
        req_o.rd = 1'b1;
        req_o.addr = addr;
        @(negedge ref_clk_i);
        data = rd_data_i;
        valid = rd_valid_i;
        idle_bus();
    endtask : read_reg
endmodule : ctrl_master_model

//--- verif/tb_dual_adc_spi_register_map.sv
/*
 * self-checking bench for the converter configuration bank.
 * assumes the package constants and the master model in the same run.
 */
`timescale 1ns/10ps
`define CHK(got, exp, what) begin checked++; if ((got) !== (exp)) begin \
    n_mismatch++; $display("FAIL t=%0t %s", $time, what); end end
module tb_dual_adc_spi_register_map import adc_regmap_pkg::*;;
    localparam logic [7:0] ID_VALUE = 8'h5A; // arbitrary value
    localparam logic [2:0] GRADE_VALUE = 3'h1; // arbitrary value
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic pin = 1'b0;
    reg_req_t req;
    logic [7:0] rd_data;
    logic rd_valid, lsb_first, stab_en;
    logic [3:0] ratio;
    logic [1:0] pd, sb, dr;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;

    always #2 ref_clk_i = ~ref_clk_i;

    dual_adc_register_map #(.NUM_CHANNELS(2), .PART_ID(ID_VALUE), .SPEED_GRADE(GRADE_VALUE))
        dual_adc_register_map_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .req_i(req),
        .external_powerdown_pin_i(pin), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
        .lsb_first_o(lsb_first), .stabilizer_en_o(stab_en), .clk_div_ratio_o(ratio),
        .powerdown_o(pd), .standby_o(sb), .digital_reset_o(dr));

    ctrl_master_model ctrl_master_model_inst (.ref_clk_i(ref_clk_i), .rd_data_i(rd_data),
        .rd_valid_i(rd_valid), .req_o(req));

    // counts and verdict, then stop
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict

    // hang guard
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ctrl_master_model_inst.write_reg(a, d);
    endtask : wr
    // commit and let the outputs follow
    task automatic commit();
        wr(ADDR_COMMIT, 8'h01);
        settle(3);
    endtask : commit
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        ctrl_master_model_inst.read_reg(a, d, v);
        `CHK(v, 1'b1, "read strobe missing")
        `CHK(d, exp, "read data wrong")
    endtask : rd_chk

    task automatic test_defaults();
        rd_chk(ADDR_PORT_CFG, 8'h18);
        rd_chk(ADDR_CH_SEL, 8'h03);
        rd_chk(ADDR_POWER_MODE, 8'h00);
        rd_chk(ADDR_CLOCK_COND, 8'h01);
        rd_chk(ADDR_CLOCK_DIV, 8'h00);
        rd_chk(ADDR_COMMIT, 8'h00);
        `CHK({lsb_first, stab_en, ratio}, 6'b010001, "idle outputs")
        `CHK({pd, sb, dr}, 6'b000000, "idle power outputs")
    endtask : test_defaults

    task automatic test_ident();
        wr(ADDR_PART_ID, 8'hFF);
        wr(ADDR_SPEED_GRADE, 8'h70);
        rd_chk(ADDR_PART_ID, ID_VALUE);
        rd_chk(ADDR_SPEED_GRADE, {1'b0, GRADE_VALUE, 4'h0});
        rd_chk(8'h13, READ_UNMAPPED);
    endtask : test_ident

    // every ratio, held back until committed
    task automatic test_divider();
        for (int f = 0; f < 8; f++) begin
            wr(ADDR_CLOCK_DIV, 8'(f));
            `CHK(ratio, (f == 0) ? 4'h1 : 4'(f), "ratio moved early")
            commit();
            `CHK(ratio, 4'(f + 1), "ratio wrong")
            rd_chk(ADDR_COMMIT, 8'h00);
            rd_chk(ADDR_CLOCK_DIV, 8'(f));
        end
    endtask : test_divider

    task automatic test_local();
        wr(ADDR_CH_SEL, 8'h01);
        wr(ADDR_POWER_MODE, 8'h01);
        wr(ADDR_CH_SEL, 8'h02);
        wr(ADDR_POWER_MODE, 8'h02);
        commit();
        `CHK({pd, sb}, 4'b0110, "per channel modes")
        rd_chk(ADDR_POWER_MODE, 8'h02);
        wr(ADDR_CH_SEL, 8'h01);
        rd_chk(ADDR_POWER_MODE, 8'h01);
        wr(ADDR_CH_SEL, 8'h03);
        rd_chk(ADDR_POWER_MODE, 8'h01);
        wr(ADDR_POWER_MODE, 8'h03);
        commit();
        `CHK(dr, 2'b11, "both copies written")
        wr(ADDR_CH_SEL, 8'h01);
        wr(ADDR_CLOCK_COND, 8'h00);
        commit();
        wr(ADDR_CH_SEL, 8'h02);
        rd_chk(ADDR_CLOCK_COND, 8'h00);
        `CHK(stab_en, 1'b0, "stabilizer off")
        wr(ADDR_CLOCK_COND, 8'h01);
        commit();
        `CHK(stab_en, 1'b1, "stabilizer on")
    endtask : test_local

    // pin gives power-down on A, standby on B
    task automatic test_pin();
        wr(ADDR_CH_SEL, 8'h01);
        wr(ADDR_POWER_MODE, 8'h00);
        wr(ADDR_CH_SEL, 8'h02);
        wr(ADDR_POWER_MODE, 8'h20);
        commit();
        `CHK({pd, sb, dr}, 6'b000000, "normal mode")
        pin = 1'b1;
        settle(3);
        `CHK({pd, sb}, 4'b0110, "pin function")
        pin = 1'b0;
        settle(3);
        `CHK({pd, sb}, 4'b0000, "pin released")
    endtask : test_pin

    task automatic test_port_cfg();
        wr(ADDR_PORT_CFG, 8'h42);
        settle(2);
        `CHK(lsb_first, 1'b1, "lsb first set")
        rd_chk(ADDR_PORT_CFG, 8'h5A);
        wr(ADDR_PORT_CFG, 8'h00);
        settle(2);
        `CHK(lsb_first, 1'b0, "lsb first clear")
        wr(ADDR_CH_SEL, 8'h01);
        wr(ADDR_CLOCK_DIV, 8'h05);
        commit();
        wr(ADDR_PORT_CFG, 8'h24);
        settle(4);
        `CHK(ratio, 4'h1, "soft reset ratio")
        rd_chk(ADDR_CH_SEL, 8'h03);
        rd_chk(ADDR_CLOCK_DIV, 8'h00);
    endtask : test_port_cfg

    // hard reset in mid-run reloads committed and buffered state
    task automatic test_hard_reset();
        wr(ADDR_CH_SEL, 8'h02);
        wr(ADDR_CLOCK_DIV, 8'h06);
        wr(ADDR_CLOCK_COND, 8'h00);
        commit();
        `CHK({stab_en, ratio}, 5'b00111, "state before reset")
        rstn_i = 1'b0;
        settle(2);
        rstn_i = 1'b1;
        settle(1);
        `CHK({lsb_first, stab_en, ratio}, 6'b010001, "outputs after reset")
        rd_chk(ADDR_CH_SEL, 8'h03);
        rd_chk(ADDR_CLOCK_DIV, 8'h00);
        rd_chk(ADDR_CLOCK_COND, 8'h01);
    endtask : test_hard_reset

    initial begin
        settle(16);
        rstn_i = 1'b1;
        settle(1);
        test_defaults();
        test_ident();
        test_divider();
        test_local();
        test_pin();
        test_port_cfg();
        test_hard_reset();
        print_verdict();
    end
endmodule : tb_dual_adc_spi_register_map
